// [rx_event_code_generator.sv]
/*
  Miscellaneous receive-queue event generator: captures event requests from
  the DMA, reassembly, cut-through, counter and buffer-pool logic, arbitrates
  them and hands one queue entry at a time to the receive queue unit, with an
  optional timestamp entry ahead of each event.
  Assumes all request inputs come from logic on sys_clk and that the queue
  unit takes an entry in any cycle where ce, entry_valid and entry_ready are high.

  // Summary of operation
  // RULE_01 - zero descriptor address: cancel, post 0x29
  // RULE_02 - 0x69 is alias encoding of 0x29
  // RULE_03 - vm boundary without segment buffer posts 0x38
  // RULE_04 - vm size overrun also posts 0x38
  // RULE_05 - info: packet pointer if bad frames, else descriptor
  // RULE_06 - real buffer size overrun posts 0x39
  // RULE_07 - cut-through without header descriptor posts 0x3a
  // RULE_08 - cut-through cancel on error posts 0x3b
  // RULE_09 - scatter buffer shortage posts 0x3c, buffer address
  // RULE_10 - software recovers pages or finishes packet
  // RULE_11 - counter overflows merge into one 0x3d
  // RULE_12 - overflow bits 27 to 23 as defined
  // RULE_13 - pool status posts 0x3e with status
  // RULE_14 - timestamp on: 0x5e before next event
  // RULE_15 - 64-bit form: 0x5f, timestamp high word
  // RULE_16 - 7-bit identifier stored beside information
  // RULE_17 - user identifiers passed through unchanged
*/
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rx_event_defs.svh"

module rx_event_code_generator
  import rx_event_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // descriptor zero address
  input wire logic desc_zero_evt,
  input wire logic [31:0] desc_zero_addr,
  output logic desc_cancel,
  // reassembly cell checks
  input wire logic cell_valid,
  input wire logic vm_cross,
  input wire logic seg_buf_avail,
  input wire logic vm_size_exceed,
  input wire logic real_size_exceed,
  input wire logic [31:0] pkt_ptr,
  input wire logic [31:0] channel_descriptor_ptr,
  // cut-through adaptation and scatter
  input wire logic ct_nodesc_evt,
  input wire logic ct_cancel_evt,
  input wire logic [31:0] ct_sys_desc_addr,
  input wire logic scatter_short_evt,
  input wire logic [31:0] scatter_buf_addr,
  // counter overflows
  input wire logic dma_wr_bytes_ovf,
  input wire logic dma_rd_bytes_ovf,
  input wire logic queue_ts_ovf,
  input wire logic host_perf1_ovf,
  input wire logic host_perf2_ovf,
  // buffer pool manager status
  input wire logic pool_status_evt,
  input wire logic [31:0] pool_status,
  // user-defined events
  input wire logic user_evt,
  input wire logic [6:0] user_id,
  input wire logic [31:0] user_info,
  // timestamp source
  input wire logic [31:0] timestamp,
  // queue entry toward the receive queue unit
  output logic entry_valid,
  output logic [6:0] entry_id,
  output logic [31:0] entry_info,
  output logic [31:0] entry_info_hi,
  input wire logic entry_ready,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic src_index_type first_set(input logic [`SRC_N-1:0] v);
    first_set = 4'h0;
    for (int i = `SRC_N - 1; i >= 0; i--)
    begin
      if (v[i])
        first_set = 4'(i);
    end
  endfunction

  function automatic logic [`SRC_N-1:0] one_hot(input src_index_type idx);
    one_hot = 9'(9'h001 << idx);
  endfunction

  function automatic event_id_type event_code(input src_index_type idx,
                                              input logic alias_sel,
                                              input event_id_type uid);
    case (idx)
      4'h0: event_code = alias_sel ? `EVT_ZERO_ALIAS : `EVT_ZERO_DESC;
      4'h1: event_code = `EVT_VM_RES;
      4'h2: event_code = `EVT_BUF_OVF;
      4'h3: event_code = `EVT_CT_NODESC;
      4'h4: event_code = `EVT_CT_CANCEL;
      4'h5: event_code = `EVT_SCATTER;
      4'h6: event_code = `EVT_CNT_OVF;
      4'h7: event_code = `EVT_POOL;
      default: event_code = uid;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_type state_reg;
  logic [`SRC_N-1:0] pend_reg;
  word_type info_reg [0:`SRC_N-1];
  event_id_type user_id_reg;
  src_index_type sel_reg;
  logic [`CTRL_W-1:0] ctrl_reg;
  logic [`STAT_W-1:0] status_reg;
  logic [`STAT_W-1:0] mask_reg;
  logic out_valid_reg;
  event_id_type out_id_reg;
  word_type out_info_reg;
  word_type out_hi_reg;
  logic cancel_reg;
  word_type rdata_reg;
  logic irq_reg;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  wire logic bad_frames = ctrl_reg[`CTRL_BADFRM];
  wire logic vm_hit = cell_valid & ((vm_cross & ~seg_buf_avail) | vm_size_exceed); // RULE_03 RULE_04
  wire logic ovf_hit = cell_valid & real_size_exceed; // RULE_06
  // user identifiers outside their range are refused and counted as lost
  wire logic user_in_range = (user_id >= `EVT_USER_LO) && (user_id <= `EVT_USER_HI);
  wire logic user_ok = user_evt & user_in_range;
  wire logic user_bad = user_evt & ~user_in_range;
  wire logic [31:0] cnt_bits = {4'h0, dma_wr_bytes_ovf, dma_rd_bytes_ovf, queue_ts_ovf,
    host_perf1_ovf, host_perf2_ovf, 23'h0}; // RULE_12
  wire logic cnt_any = |cnt_bits;
  wire logic [31:0] frame_ptr = bad_frames ? pkt_ptr : channel_descriptor_ptr; // RULE_05
  wire logic [`SRC_N-1:0] set_vec = {user_ok, pool_status_evt, cnt_any, scatter_short_evt,
    ct_cancel_evt, ct_nodesc_evt, ovf_hit, vm_hit, desc_zero_evt}; // RULE_07 RULE_08 RULE_09

  word_type new_info [0:`SRC_N-1];
  assign new_info[`SRC_ZERO] = desc_zero_addr; // RULE_01
  assign new_info[`SRC_VM] = frame_ptr;
  assign new_info[`SRC_OVF] = frame_ptr;
  assign new_info[`SRC_CT_NODESC] = frame_ptr;
  assign new_info[`SRC_CT_CANCEL] = ct_sys_desc_addr; // RULE_08
  assign new_info[`SRC_SCATTER] = scatter_buf_addr; // RULE_09
  assign new_info[`SRC_CNT] = cnt_bits;
  assign new_info[`SRC_POOL] = pool_status; // RULE_13
  assign new_info[`SRC_USER] = user_info;

  // ----------------------------------------------------------------
  // arbitration and entry loading
  // ----------------------------------------------------------------
  wire logic ts_on = ctrl_reg[`CTRL_TS_EN];
  wire logic ts64 = ctrl_reg[`CTRL_TS64];
  wire logic out_free = ~out_valid_reg | entry_ready;
  wire logic any_pend = |pend_reg;
  wire src_index_type first_idx = first_set(pend_reg);
  wire logic idle_go = (state_reg == st_idle) & out_free & any_pend;
  wire logic load_stamp = idle_go & ts_on; // RULE_14
  wire logic load_event = (idle_go & ~ts_on) | ((state_reg == st_stamp) & out_free);
  wire src_index_type ev_idx = (state_reg == st_stamp) ? sel_reg : first_idx;
  wire logic [`SRC_N-1:0] clr_vec = load_event ? one_hot(ev_idx) : 9'h000;
  // a new request in the cycle its slot is emptied is kept, not lost
  wire logic [`SRC_N-1:0] take_vec = set_vec & (~pend_reg | clr_vec);
  wire logic [`SRC_N-1:0] lost_vec = set_vec & pend_reg & ~clr_vec & ~one_hot(4'(`SRC_CNT));
  wire logic [`SRC_N-1:0] pend_next = (pend_reg & ~clr_vec) | set_vec;
  wire event_id_type stamp_id = ts64 ? `EVT_TS64 : `EVT_TS32;

  wire logic out_valid_next = out_free ? (load_stamp | load_event) : 1'b1;
  wire event_id_type out_id_next = load_stamp ? stamp_id :
    load_event ? event_code(ev_idx, ctrl_reg[`CTRL_ALIAS], user_id_reg) : out_id_reg; // RULE_02 RULE_16 RULE_17
  wire word_type out_info_next = load_stamp ? (ts64 ? 32'h0 : timestamp) :
    load_event ? info_reg[ev_idx] : out_info_reg; // RULE_14
  wire word_type out_hi_next = load_stamp ? (ts64 ? timestamp : 32'h0) :
    load_event ? 32'h0 : out_hi_reg; // RULE_15

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= st_idle;
      sel_reg <= 4'h0;
    end
    else if (ce)
    begin
      if (load_stamp)
      begin
        state_reg <= st_stamp;
        sel_reg <= first_idx;
      end
      else if (load_event)
        state_reg <= st_idle;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_reg <= 9'h000;
      user_id_reg <= 7'h00;
      for (int i = 0; i < `SRC_N; i++)
        info_reg[i] <= 32'h0;
    end
    else if (ce)
    begin
      pend_reg <= pend_next;
      if (take_vec[`SRC_USER])
        user_id_reg <= user_id;
      for (int i = 0; i < `SRC_N; i++)
      begin
        // overflow bits accumulate until the event is loaded into the output entry
        if (i == `SRC_CNT)
          info_reg[i] <= (clr_vec[i] ? 32'h0 : info_reg[i]) | new_info[i]; // RULE_11
        else if (take_vec[i])
          info_reg[i] <= new_info[i];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid_reg <= 1'b0;
      out_id_reg <= 7'h00;
      out_info_reg <= 32'h0;
      out_hi_reg <= 32'h0;
      cancel_reg <= 1'b0;
    end
    else if (ce)
    begin
      out_valid_reg <= out_valid_next;
      out_id_reg <= out_id_next;
      out_info_reg <= out_info_next;
      out_hi_reg <= out_hi_next;
      cancel_reg <= desc_zero_evt; // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  wire logic hit_ctrl = reg_addr == `REG_CTRL;
  wire logic hit_status = reg_addr == `REG_STATUS;
  wire logic hit_mask = reg_addr == `REG_MASK;
  wire logic hit_pend = reg_addr == `REG_PEND;
  wire logic [`STAT_W-1:0] stat_set = {(|lost_vec) | user_bad, clr_vec};
  // read clears, but an event landing in the same cycle stays set
  wire logic [`STAT_W-1:0] status_next =
    ((reg_rd & hit_status) ? 10'h000 : status_reg) | stat_set;
  wire word_type rdata_next = ~reg_rd ? 32'h0 :
    hit_ctrl ? {28'h0, ctrl_reg} :
    hit_status ? {22'h0, status_reg} :
    hit_mask ? {22'h0, mask_reg} :
    hit_pend ? {23'h0, pend_reg} : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
      status_reg <= 10'h000;
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (reg_wr & hit_ctrl)
        ctrl_reg <= reg_wdata[`CTRL_W-1:0];
      if (reg_wr & hit_mask)
        mask_reg <= reg_wdata[`STAT_W-1:0];
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign entry_valid = out_valid_reg;
  assign entry_id = out_id_reg;
  assign entry_info = out_info_reg;
  assign entry_info_hi = out_hi_reg;
  assign desc_cancel = cancel_reg;
  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_cancel_follows: assert property (ce && desc_zero_evt |=> desc_cancel) // RULE_01
    else $error("zero-address descriptor not cancelled");
  a_zero_alias: assert property (ce && load_event && ev_idx == 4'h0 |=> // RULE_02
    entry_id == ($past(ctrl_reg[`CTRL_ALIAS]) ? `EVT_ZERO_ALIAS : `EVT_ZERO_DESC))
    else $error("zero-address event code wrong");
  a_vm_boundary: assert property (ce && cell_valid && vm_cross && !seg_buf_avail // RULE_03
    |=> pend_reg[`SRC_VM] || (entry_valid && entry_id == `EVT_VM_RES))
    else $error("vm boundary event missing");
  a_vm_size: assert property (ce && cell_valid && vm_size_exceed |=> pend_reg[`SRC_VM]) // RULE_04
    else $error("vm size event missing");
  a_ptr_select: assert property (ce && take_vec[`SRC_OVF] |=> info_reg[`SRC_OVF] == // RULE_05
    ($past(ctrl_reg[`CTRL_BADFRM]) ? $past(pkt_ptr) : $past(channel_descriptor_ptr)))
    else $error("overflow event pointer wrong");
  a_real_size: assert property (ce && cell_valid && real_size_exceed |=> pend_reg[`SRC_OVF]) // RULE_06
    else $error("buffer overflow event missing");
  a_cnt_merge: assert property (ce && dma_wr_bytes_ovf && queue_ts_ovf |=> // RULE_11
    pend_reg[`SRC_CNT] && info_reg[`SRC_CNT][`CNT_WR_BIT] && info_reg[`SRC_CNT][`CNT_TS_BIT])
    else $error("counter overflows not merged");
  a_cnt_bits: assert property (ce && host_perf2_ovf && !load_event |=> // RULE_12
    info_reg[`SRC_CNT][`CNT_PERF2_BIT] && !info_reg[`SRC_CNT][31])
    else $error("counter overflow bit misplaced");
  a_stamp_ahead: assert property (ce && load_stamp && !ts64 |=> // RULE_14
    entry_valid && entry_id == `EVT_TS32 && entry_info == $past(timestamp))
    else $error("32-bit timestamp entry wrong");
  a_stamp_wide: assert property (ce && load_stamp && ts64 |=> // RULE_15
    entry_id == `EVT_TS64 && entry_info_hi == $past(timestamp) && state_reg == st_stamp)
    else $error("64-bit timestamp entry wrong");
  a_entry_hold: assert property (entry_valid && !entry_ready |=> // RULE_16
    entry_valid && $stable(entry_id) && $stable(entry_info))
    else $error("entry changed before taken");
  a_user_pass: assert property (ce && load_event && ev_idx == 4'h8 |=> // RULE_17
    entry_id == $past(user_id_reg))
    else $error("user identifier altered");

  c_stamp_pair: cover property (ce && load_stamp ##[1:4] ce && load_event);
  c_cnt_multi: cover property (ce && dma_rd_bytes_ovf && host_perf1_ovf);
  c_lost_req: cover property (ce && |lost_vec);
  c_irq_up: cover property (!irq ##1 irq);

endmodule
`default_nettype wire

// [rx_event_code_generator_tb.sv]
/*
  Self-checking testbench for the receive-queue event generator: a queue model of
  expected entries is compared with every entry taken from the design.
  Assumes the design files and rx_event_defs.svh are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rx_event_defs.svh"

module rx_event_code_generator_tb
  import rx_event_pkg::*;
;
  logic sys_clk, rst, ce, entry_ready, reg_wr, reg_rd, stall;
  logic desc_cancel, entry_valid, irq;
  logic vm_cross, seg_buf_avail, vm_size_exceed, real_size_exceed;
  logic [6:0] pulse;
  logic [4:0] ovf;
  word_type desc_zero_addr, pkt_ptr, channel_descriptor_ptr, ct_sys_desc_addr;
  word_type scatter_buf_addr, pool_status, user_info, timestamp, entry_info, entry_info_hi;
  word_type reg_wdata, reg_rdata;
  event_id_type user_id, entry_id;
  logic [`ADDR_W-1:0] reg_addr;
  event_id_type q_id[$];
  word_type q_info[$];
  word_type q_hi[$];
  logic [3:0] ctrl_m;
  int n_fail, n_checks;

  rx_event_code_generator i_rx_event_code_generator (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .desc_zero_evt(pulse[0]), .desc_zero_addr(desc_zero_addr), .desc_cancel(desc_cancel),
    .cell_valid(pulse[1]), .vm_cross(vm_cross), .seg_buf_avail(seg_buf_avail),
    .vm_size_exceed(vm_size_exceed), .real_size_exceed(real_size_exceed),
    .pkt_ptr(pkt_ptr), .channel_descriptor_ptr(channel_descriptor_ptr),
    .ct_nodesc_evt(pulse[2]), .ct_cancel_evt(pulse[3]), .ct_sys_desc_addr(ct_sys_desc_addr),
    .scatter_short_evt(pulse[4]), .scatter_buf_addr(scatter_buf_addr),
    .dma_wr_bytes_ovf(ovf[4]), .dma_rd_bytes_ovf(ovf[3]), .queue_ts_ovf(ovf[2]),
    .host_perf1_ovf(ovf[1]), .host_perf2_ovf(ovf[0]),
    .pool_status_evt(pulse[5]), .pool_status(pool_status),
    .user_evt(pulse[6]), .user_id(user_id), .user_info(user_info),
    .timestamp(timestamp),
    .entry_valid(entry_valid), .entry_id(entry_id), .entry_info(entry_info),
    .entry_info_hi(entry_info_hi), .entry_ready(entry_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  // ----------------------------------------------------------------
  // clock, queue-side stalls, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    entry_ready <= !stall && ($urandom % 4 != 0);

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // checking helpers and model
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // every taken entry must be the oldest one the model expects
  always @(posedge sys_clk)
    if (!rst && ce && entry_valid === 1'b1 && entry_ready)
    begin
      if (q_id.size() == 0)
        chk({25'h0, entry_id}, 32'hffff_ffff);
      else
      begin
        chk({25'h0, entry_id}, {25'h0, q_id.pop_front()});
        chk(entry_info, q_info.pop_front());
        chk(entry_info_hi, q_hi.pop_front());
      end
    end

  task automatic expect_entry(input event_id_type id, input word_type info);
    if (ctrl_m[`CTRL_TS_EN])
    begin
      q_id.push_back(ctrl_m[`CTRL_TS64] ? `EVT_TS64 : `EVT_TS32);
      q_info.push_back(ctrl_m[`CTRL_TS64] ? 32'h0 : timestamp);
      q_hi.push_back(ctrl_m[`CTRL_TS64] ? timestamp : 32'h0);
    end
    q_id.push_back(id);
    q_info.push_back(info);
    q_hi.push_back(32'h0);
  endtask

  function automatic event_id_type exp_id(input int k, input event_id_type uid);
    case (k)
      0: return ctrl_m[`CTRL_ALIAS] ? `EVT_ZERO_ALIAS : `EVT_ZERO_DESC;
      1, 2: return `EVT_VM_RES;
      3: return `EVT_BUF_OVF;
      4: return `EVT_CT_NODESC;
      5: return `EVT_CT_CANCEL;
      6: return `EVT_SCATTER;
      7: return `EVT_CNT_OVF;
      8: return `EVT_POOL;
      default: return uid;
    endcase
  endfunction

  function automatic word_type exp_info(input int k, input word_type v);
    if (k >= 1 && k <= 4)
      return ctrl_m[`CTRL_BADFRM] ? v : ~v;
    if (k == 7)
      return word_type'(v[4:0]) << `CNT_PERF2_BIT;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  // k picks the source: 0 zero desc, 1 vm boundary, 2 vm size, 3 real size,
  // 4 no header desc, 5 cut-through cancel, 6 scatter, 7 counters, 8 pool, 9 user
  task automatic fire(input int k, input word_type v, input event_id_type uid);
    @(posedge sys_clk);
    pulse <= {k == 9, k == 8, k == 6, k == 5, k == 4, k >= 1 && k <= 3, k == 0};
    ovf <= (k == 7) ? v[4:0] : 5'h0;
    vm_cross <= (k == 1);
    seg_buf_avail <= (k != 1);
    vm_size_exceed <= (k == 2);
    real_size_exceed <= (k == 3);
    {desc_zero_addr, ct_sys_desc_addr, scatter_buf_addr} <= {v, v, v};
    {pkt_ptr, channel_descriptor_ptr, pool_status, user_info} <= {v, ~v, v, v};
    user_id <= uid;
    @(posedge sys_clk);
    pulse <= 7'h0;
    ovf <= 5'h0;
    #1;
    if (k == 0)
      chk(desc_cancel, 1'b1);
  endtask

  task automatic rd(input logic [`ADDR_W-1:0] a, input word_type e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic wr(input logic [`ADDR_W-1:0] a, input word_type d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic drain();
    int i;
    for (i = 0; i < 300 && (q_id.size() != 0 || entry_valid !== 1'b0); i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk(32'(q_id.size()), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int m, k;
    word_type v, a, b;
    logic [19:0] modes;
    modes = 20'h6_2_9_1_0;
    {rst, ce, stall, reg_wr, reg_rd, reg_addr, reg_wdata, pulse, ovf} = '0;
    {vm_cross, vm_size_exceed, real_size_exceed, user_id, user_info} = '0;
    {desc_zero_addr, pkt_ptr, channel_descriptor_ptr, ct_sys_desc_addr} = '0;
    {scatter_buf_addr, pool_status, timestamp} = '0;
    rst = 1'b1;
    ce = 1'b1;
    seg_buf_avail = 1'b1;
    ctrl_m = 4'h0;
    v = $urandom(32'h22a14fe9);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    rd(`REG_CTRL, 32'h0);
    rd(`REG_MASK, 32'h0);
    rd(`REG_STATUS, 32'h0);
    rd(`REG_PEND, 32'h0);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, 32'h0);
    wr(`REG_STATUS, 32'hffff_ffff);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, 32'hffff_ffff);
    rd(`REG_CTRL, 32'h0000_000f);
    wr(`REG_MASK, 32'hffff_ffff);
    rd(`REG_MASK, 32'h0000_03ff);
    // every source under each of the five control modes in modes
    for (m = 0; m < 5; m++)
    begin
      ctrl_m = modes[m*4 +: 4];
      @(posedge sys_clk);
      timestamp <= $urandom;
      wr(`REG_CTRL, {28'h0, ctrl_m});
      wr(`REG_MASK, (m == 1) ? 32'h3ff : 32'h0);
      for (k = 0; k < 10; k++)
      begin
        v = $urandom | 32'h1;
        fire(k, v, 7'h30 + v[2:0]);
        expect_entry(exp_id(k, 7'h30 + v[2:0]), exp_info(k, v));
        drain();
        chk(irq, m == 1);
        rd(`REG_STATUS, 32'h1 << (k - (k >= 2)));
        @(posedge sys_clk);
        #1;
        chk(irq, 1'b0);
      end
    end
    // stalled queue: refusal, merging of overflows, priority
    ctrl_m = 4'h0;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_MASK, 32'h200);
    stall <= 1'b1;
    a = $urandom | 32'h1;
    b = $urandom;
    fire(8, a, 7'h0);
    fire(8, b, 7'h0);
    fire(8, ~b, 7'h0);
    fire(7, 32'h11, 7'h0);
    fire(7, 32'h06, 7'h0);
    fire(9, a, 7'h40);
    rd(`REG_PEND, 32'h0000_00c0);
    chk(irq, 1'b1);
    expect_entry(`EVT_POOL, a);
    expect_entry(`EVT_CNT_OVF, exp_info(7, 32'h17));
    expect_entry(`EVT_POOL, b);
    // frozen clock enable: nothing may be taken or change
    @(posedge sys_clk);
    ce <= 1'b0;
    stall <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(32'(q_id.size()), 32'h3);
    chk({25'h0, entry_id}, {25'h0, `EVT_POOL});
    @(posedge sys_clk);
    ce <= 1'b1;
    drain();
    rd(`REG_STATUS, 32'h0000_02c0);
    @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    // out-of-range user identifier alone: refused, flagged lost
    fire(9, a, 7'h41);
    drain();
    rd(`REG_STATUS, 32'h0000_0200);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// [rx_event_defs.svh]
/*
  Constants for the miscellaneous receive-queue event generator:
  event identifiers, counter-overflow bit positions, register offsets,
  control bit positions and source slot indices.
  Assumes inclusion by bare name from the design files.
*/
`ifndef RX_EVENT_DEFS_SVH
`define RX_EVENT_DEFS_SVH

// ----------------------------------------------------------------
// event identifiers (7 bits)
// ----------------------------------------------------------------
`define EVT_ZERO_DESC 7'h29
`define EVT_ZERO_ALIAS 7'h69
`define EVT_VM_RES 7'h38
`define EVT_BUF_OVF 7'h39
`define EVT_CT_NODESC 7'h3a
`define EVT_CT_CANCEL 7'h3b
`define EVT_SCATTER 7'h3c
`define EVT_CNT_OVF 7'h3d
`define EVT_POOL 7'h3e
`define EVT_TS32 7'h5e
`define EVT_TS64 7'h5f
`define EVT_USER_LO 7'h30
`define EVT_USER_HI 7'h37

// ----------------------------------------------------------------
// counter-overflow information bits
// ----------------------------------------------------------------
`define CNT_WR_BIT 27
`define CNT_RD_BIT 26
`define CNT_TS_BIT 25
`define CNT_PERF1_BIT 24
`define CNT_PERF2_BIT 23

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_MASK 4'h8
`define REG_PEND 4'hc
`define CTRL_W 4
`define CTRL_BADFRM 0
`define CTRL_TS_EN 1
`define CTRL_TS64 2
`define CTRL_ALIAS 3
`define CTRL_RESET 4'h0
`define MASK_RESET 10'h000
`define STAT_W 10
`define STAT_LOST 9

// ----------------------------------------------------------------
// source slots, lowest index wins arbitration
// ----------------------------------------------------------------
`define SRC_N 9
`define SRC_ZERO 0
`define SRC_VM 1
`define SRC_OVF 2
`define SRC_CT_NODESC 3
`define SRC_CT_CANCEL 4
`define SRC_SCATTER 5
`define SRC_CNT 6
`define SRC_POOL 7
`define SRC_USER 8

`endif

// [rx_event_pkg.sv]
/*
  Types shared by the receive-queue event generator.
  Assumes nothing of its surroundings.
*/
package rx_event_pkg;
  typedef enum logic [0:0] {st_idle, st_stamp} state_type;
  typedef logic [6:0] event_id_type;
  typedef logic [31:0] word_type;
  typedef logic [3:0] src_index_type;
endpackage
